/* File: mcgtx.v */
// Manchester code transmitter with its transmit FIFO
`timescale 1ns/1ps
// How it works
// - A unit carries one to eight bits, count setting plus one.
// - Nothing is sent while the unit enable bit is clear.
// - Between units the pin holds the idle level select bit.
// - Software sets the bit count, then a buffer write starts sending.
// - At start, count goes to a 3-bit counter, data to shifter.
// - A load pulse is raised when data enters the shift register.
// - Shifter advances per baud period; pin is bit XOR baud clock, or the bit alone when the format bit is set.
// - The bit sent with counter at zero ends the unit.
// - A late write starts the next unit two base clocks after the end.
// - Baud divisor is five bits, values below four act as four.
// - Base clock source is chosen by a three-bit field.
// - Port direction resets to all ones; zero enables the driver.
// - Baud clock is base clock over divisor, then over two.
// - Base select codes 0 to 5 divide by powers of two.

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module mcgtx_fifo #(
  parameter W = 11,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < D; i = i + 1) begin
        mem_q[i] <= {W{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// Transmitter top
// ----------------------------------------
module mcgtx_top (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register access
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output wire tx_buffer_ready,
  // Events
  output reg tx_load_irq,
  // Port pins
  output reg coded_out_pin,
  output wire shared_port_pin_o,
  output wire shared_port_pin_oe_n,
  output wire [7:0] port3_direction
);
`include "mcgtx_defs.vh"

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_GAP = 3'b010;
  localparam [2:0] ST_SEND = 3'b100;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctl_a_q;
  reg [2:0] ctl_b_q;
  reg [4:0] ctl_c_q;
  reg [2:0] bitcnt_q;
  reg [7:0] txbuf_q;
  reg [7:0] port3_dir_q;
  wire enable;
  wire lsb_first;
  wire fmt_seq;
  wire idle_lvl;
  wire wr_txbuf;
  wire fifo_valid;
  wire fifo_pop;
  wire [10:0] fifo_data;

  assign enable = ctl_a_q[`MCGTX_A_ENABLE];
  assign lsb_first = ctl_a_q[`MCGTX_A_ORDER];
  assign fmt_seq = ctl_a_q[`MCGTX_A_FORMAT];
  assign idle_lvl = ctl_a_q[`MCGTX_A_IDLE];
  assign wr_txbuf = reg_wr && (reg_addr == `MCGTX_ADDR_TXBUF);
  assign port3_direction = port3_dir_q;
  assign shared_port_pin_oe_n = port3_dir_q[`MCGTX_SHARED_PIN_BIT];
  assign shared_port_pin_o = coded_out_pin;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_a_q <= `MCGTX_RST_CTL_A;
      ctl_b_q <= `MCGTX_RST_CTL_B;
      ctl_c_q <= `MCGTX_RST_CTL_C;
      bitcnt_q <= `MCGTX_RST_BITCNT;
      txbuf_q <= 8'h00;
      port3_dir_q <= `MCGTX_RST_PORT3_DIR;
    end else if (reg_wr) begin
      if (reg_addr == `MCGTX_ADDR_CTL_A) begin
        ctl_a_q <= reg_wdata & 8'h93;
      end else if (reg_addr == `MCGTX_ADDR_CTL_B) begin
        ctl_b_q <= reg_wdata[2:0];
      end else if (reg_addr == `MCGTX_ADDR_CTL_C) begin
        ctl_c_q <= reg_wdata[4:0];
      end else if (reg_addr == `MCGTX_ADDR_BITCNT) begin
        bitcnt_q <= reg_wdata[2:0];
      end else if (reg_addr == `MCGTX_ADDR_TXBUF) begin
        txbuf_q <= reg_wdata;
      end else if (reg_addr == `MCGTX_ADDR_PORT3_DIR) begin
        port3_dir_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Buffer writes pair data with the count
  // ----------------------------------------
  mcgtx_fifo #(
    .W(11),
    .D(`MCGTX_FIFO_DEPTH),
    .AW(`MCGTX_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wr_txbuf),
    .in_ready(tx_buffer_ready),
    .in_data({bitcnt_q, reg_wdata}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // Baud generation
  // ----------------------------------------
  reg [4:0] presc_q;
  reg [4:0] half_q;
  reg [4:0] kk;
  reg [4:0] presc_mask;
  wire base_tick;
  wire half_tick;

  always @* begin
    kk = (ctl_c_q < `MCGTX_K_MIN) ? `MCGTX_K_MIN : ctl_c_q;
    presc_mask = 5'h00;
    case (ctl_b_q)
      3'h0: presc_mask = 5'h00;
      3'h1: presc_mask = 5'h01;
      3'h2: presc_mask = 5'h03;
      3'h3: presc_mask = 5'h07;
      3'h4: presc_mask = 5'h0f;
      default: presc_mask = 5'h1f;
    endcase
  end

  // Prohibited select codes give no base clock
  assign base_tick = enable && (ctl_b_q <= `MCGTX_CKS_MAX) &&
    (presc_q == presc_mask);
  assign half_tick = base_tick && (half_q == kk - 5'h01);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc_q <= 5'h00;
    end else if (!enable || presc_q == presc_mask) begin
      presc_q <= 5'h00;
    end else begin
      presc_q <= presc_q + 5'h01;
    end
  end

  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [7:0] shift_q;
  reg [2:0] cnt_q;
  reg phase_q;
  reg early_q;
  reg [1:0] gap_q;
  reg load;
  reg [7:0] load_data;
  wire cur_bit;
  wire last_bit;
  wire bit_end;
  wire window_tick;

  assign cur_bit = lsb_first ? shift_q[0] : shift_q[7];
  assign last_bit = (cnt_q == 3'h0);
  assign bit_end = (st_q == ST_SEND) && half_tick && phase_q;
  // One base clock before mid of the final bit
  assign window_tick = (st_q == ST_SEND) && last_bit && !phase_q &&
    base_tick && (half_q == kk - 5'h02);
  assign fifo_pop = load;

  always @* begin
    st_d = st_q;
    load = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (enable && fifo_valid) begin
          load = 1'b1;
          st_d = ST_SEND;
        end
      end
      ST_GAP: begin
        if (base_tick && gap_q == `MCGTX_LATE_GAP_TICKS - 2'h1) begin
          load = 1'b1;
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (bit_end && last_bit) begin
          if (early_q) begin
            load = 1'b1;
          end else if (fifo_valid) begin
            st_d = ST_GAP;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (!enable) begin
      st_d = ST_IDLE;
      load = 1'b0;
    end
  end

  always @* begin
    // Short MSB-first units send the low bits of the data
    load_data = lsb_first ? fifo_data[7:0] :
      (fifo_data[7:0] << (3'h7 - fifo_data[10:8]));
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 3'h0;
      phase_q <= 1'b0;
      half_q <= 5'h00;
      early_q <= 1'b0;
      gap_q <= 2'h0;
      tx_load_irq <= 1'b0;
    end else begin
      st_q <= st_d;
      tx_load_irq <= load;
      if (load) begin
        shift_q <= load_data;
        cnt_q <= fifo_data[10:8];
        phase_q <= 1'b0;
        half_q <= 5'h00;
        early_q <= 1'b0;
      end else if (st_q == ST_SEND) begin
        if (base_tick) begin
          half_q <= half_tick ? 5'h00 : half_q + 5'h01;
        end
        if (window_tick) begin
          early_q <= fifo_valid;
        end
        if (half_tick) begin
          phase_q <= ~phase_q;
        end
        if (bit_end) begin
          shift_q <= lsb_first ? {1'b0, shift_q[7:1]} :
            {shift_q[6:0], 1'b0};
          cnt_q <= cnt_q - 3'h1;
        end
      end
      if (st_q == ST_GAP) begin
        if (base_tick) begin
          gap_q <= gap_q + 2'h1;
        end
      end else begin
        gap_q <= 2'h0;
      end
    end
  end

  // ----------------------------------------
  // Pin and read data
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coded_out_pin <= 1'b0;
    end else if (st_q == ST_SEND && enable) begin
      coded_out_pin <= fmt_seq ? cur_bit : (cur_bit ^ phase_q);
    end else begin
      coded_out_pin <= idle_lvl;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `MCGTX_ADDR_CTL_A) begin
        reg_rdata <= ctl_a_q;
      end else if (reg_addr == `MCGTX_ADDR_CTL_B) begin
        reg_rdata <= {5'h00, ctl_b_q};
      end else if (reg_addr == `MCGTX_ADDR_CTL_C) begin
        reg_rdata <= {3'h0, ctl_c_q};
      end else if (reg_addr == `MCGTX_ADDR_BITCNT) begin
        reg_rdata <= {5'h00, bitcnt_q};
      end else if (reg_addr == `MCGTX_ADDR_TXBUF) begin
        reg_rdata <= txbuf_q;
      end else if (reg_addr == `MCGTX_ADDR_STATUS) begin
        reg_rdata <= {5'h00, fifo_valid, ~tx_buffer_ready,
          st_q != ST_IDLE};
      end else if (reg_addr == `MCGTX_ADDR_PORT3_DIR) begin
        reg_rdata <= port3_dir_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule

/* File: mcgtx_defs.vh */
// Register map, field positions, reset values and timing counts
`ifndef MCGTX_DEFS_VH
`define MCGTX_DEFS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define MCGTX_ADDR_CTL_A 16'hff4c
`define MCGTX_ADDR_CTL_B 16'hff4d
`define MCGTX_ADDR_CTL_C 16'hff4e
`define MCGTX_ADDR_TXBUF 16'hff4f
`define MCGTX_ADDR_BITCNT 16'hff50
`define MCGTX_ADDR_STATUS 16'hff51
`define MCGTX_ADDR_PORT3_DIR 16'hff23

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCGTX_A_ENABLE 7
`define MCGTX_A_ORDER 4
`define MCGTX_A_FORMAT 1
`define MCGTX_A_IDLE 0
`define MCGTX_SHARED_PIN_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCGTX_RST_CTL_A 8'h10
`define MCGTX_RST_CTL_B 3'h0
`define MCGTX_RST_CTL_C 5'h1f
`define MCGTX_RST_BITCNT 3'h7
`define MCGTX_RST_PORT3_DIR 8'hff

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define MCGTX_K_MIN 5'h04
`define MCGTX_LATE_GAP_TICKS 2'h2
`define MCGTX_CKS_MAX 3'h5
`define MCGTX_FIFO_DEPTH 4
`define MCGTX_FIFO_AW 2

`endif

/* File: mcgtx_top_sva.sv */
// Checker on the transmitter top ports
`timescale 1ns/1ps
`include "mcgtx_defs.vh"
module mcgtx_top_sva (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register access
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire tx_buffer_ready,
  // Events and pins
  input wire tx_load_irq,
  input wire coded_out_pin,
  input wire shared_port_pin_o,
  input wire shared_port_pin_oe_n,
  input wire [7:0] port3_direction
);
  reg en_q;
  reg idle_q;
  reg [1:0] off_q;
  wire wa = reg_wr && reg_addr == `MCGTX_ADDR_CTL_A;
  wire wd = reg_wr && reg_addr == `MCGTX_ADDR_PORT3_DIR;
  // Shadow of enable and idle level
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
      idle_q <= 1'b0;
      off_q <= 2'h0;
    end else begin
      if (wa) begin
        en_q <= reg_wdata[`MCGTX_A_ENABLE];
        idle_q <= reg_wdata[`MCGTX_A_IDLE];
      end
      if (en_q)
        off_q <= 2'h0;
      else if (off_q != 2'h3)
        off_q <= off_q + 2'h1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_load_gap: assert property (tx_load_irq |=> !tx_load_irq [*7])
    else $error("load pulses too close");
  a_load_enabled: assert property (tx_load_irq |-> en_q && $past(en_q))
    else $error("load while disabled");
  a_half_hold: assert property (tx_load_irq |=> ##1
    $stable(coded_out_pin) [*3])
    else $error("half bit shorter than four clocks");
  a_idle_off: assert property (off_q == 2'h3 && idle_q == $past(idle_q, 3)
    |-> coded_out_pin == idle_q)
    else $error("pin not at idle level while disabled");
  a_oe_dir: assert property (shared_port_pin_oe_n == port3_direction[2])
    else $error("driver enable differs from direction bit");
  a_dir_write: assert property (wd |=> port3_direction == $past(reg_wdata))
    else $error("direction write lost");
  a_dir_reset: assert property ($rose(resetn)
    |-> port3_direction == `MCGTX_RST_PORT3_DIR)
    else $error("direction not all ones after reset");
  a_pin_mirror: assert property (shared_port_pin_o == coded_out_pin)
    else $error("shared pin differs from coded output");
  c_load: cover property (tx_load_irq);
  c_full: cover property (!tx_buffer_ready);
  c_idle_hi: cover property (off_q == 2'h3 && idle_q);
endmodule
bind mcgtx_top mcgtx_top_sva u_sva (
  .clk(clk),
  .resetn(resetn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .tx_buffer_ready(tx_buffer_ready),
  .tx_load_irq(tx_load_irq),
  .coded_out_pin(coded_out_pin),
  .shared_port_pin_o(shared_port_pin_o),
  .shared_port_pin_oe_n(shared_port_pin_oe_n),
  .port3_direction(port3_direction)
);

/* File: mcgtx_rx_model.sv */
// Receiver model decoding the coded line
`timescale 1ns/1ps
module mcgtx_rx_model (
  // Clock and line
  input wire clk,
  input wire line_in,
  input wire start,
  // Settings
  input wire [11:0] half,
  input wire [3:0] nbits,
  // Decoded unit
  output reg [7:0] word,
  output reg [3:0] count,
  output reg bad
);
  integer i;
  reg first;
  initial begin
    word = 8'h00;
    count = 4'h0;
    bad = 1'b0;
  end
  // Bit i: first half at level, second half inverted
  always @(posedge clk) begin
    if (start === 1'b1) begin
      word = 8'h00;
      count = 4'h0;
      @(posedge clk);
      for (i = 0; i < nbits; i = i + 1) begin
        first = line_in;
        repeat (half) @(posedge clk);
        if (line_in === first)
          bad = 1'b1;
        word[i] = first;
        count = count + 4'h1;
        if (i < nbits - 1)
          repeat (half) @(posedge clk);
      end
    end
  end
endmodule

/* File: mcgtx_top_tb.sv */
// Self-checking bench for the transmitter top
`timescale 1ns/1ps
`include "mcgtx_defs.vh"
module mcgtx_top_tb;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg [11:0] half = 12'h004;
  reg [3:0] nbits = 4'h1;
  wire [7:0] rdata, p3dir, rx_word;
  wire [3:0] rx_count;
  wire rdy, irq, pin, pin_o, oe_n, rx_bad;
  integer errors = 0;
  integer n_tests = 0;
  integer n_irq = 0;
  integer cyc = 0;
  integer last = 0;
  integer gap = 0;
  integer t, n0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      n_irq <= n_irq + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  mcgtx_top DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .tx_buffer_ready(rdy), .tx_load_irq(irq),
    .coded_out_pin(pin), .shared_port_pin_o(pin_o),
    .shared_port_pin_oe_n(oe_n), .port3_direction(p3dir));
  mcgtx_rx_model u_rx (.clk(clk), .line_in(pin_o), .start(irq),
    .half(half), .nbits(nbits), .word(rx_word), .count(rx_count),
    .bad(rx_bad));
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
    end
  endtask
  task rdc(input [15:0] a, input [7:0] e);
    begin
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      chk(rdata, e);
    end
  endtask
  task wirq;
    begin
      t = 0;
      while (irq !== 1'b1 && t < 4000) begin
        @(posedge clk);
        #1;
        t = t + 1;
      end
      chk(t < 4000, 1);
    end
  endtask
  task unit(input [2:0] cks, input [4:0] k, input [7:0] ca,
    input [2:0] cnt, input [7:0] v, input [7:0] e);
    begin
      wr(`MCGTX_ADDR_CTL_A, 8'h00);
      wr(`MCGTX_ADDR_CTL_B, {5'h00, cks});
      wr(`MCGTX_ADDR_CTL_C, {3'h0, k});
      wr(`MCGTX_ADDR_CTL_A, ca);
      half = (k < 5'h04 ? 12'h004 : {7'h00, k}) << cks;
      nbits = {1'b0, cnt} + 4'h1;
      wr(`MCGTX_ADDR_BITCNT, {5'h00, cnt});
      wr(`MCGTX_ADDR_TXBUF, v);
      wirq;
      repeat (2 * half * nbits + 4) @(posedge clk);
      #1;
      chk(rx_word, e);
      chk(rx_count, nbits);
      chk(rx_bad, 0);
      chk(pin, ca[0]);
      $display("unit done at %0t", $time);
    end
  endtask
  task t_regs;
    begin
      rdc(`MCGTX_ADDR_CTL_A, 8'h10);
      rdc(`MCGTX_ADDR_CTL_B, 8'h00);
      rdc(`MCGTX_ADDR_CTL_C, 8'h1f);
      rdc(`MCGTX_ADDR_BITCNT, 8'h07);
      rdc(`MCGTX_ADDR_PORT3_DIR, 8'hff);
      rdc(16'hff00, 8'h00);
      rdc(`MCGTX_ADDR_STATUS, 8'h00);
      chk(oe_n, 1);
      wr(`MCGTX_ADDR_PORT3_DIR, 8'hfb);
      @(posedge clk);
      #1;
      chk(p3dir, 8'hfb);
      chk(oe_n, 0);
      wr(`MCGTX_ADDR_CTL_A, 8'hff);
      rdc(`MCGTX_ADDR_CTL_A, 8'h93);
      $display("regs done at %0t", $time);
    end
  endtask
  task t_stream;
    begin
      n0 = n_irq;
      wr(`MCGTX_ADDR_BITCNT, 8'h07);
      t = 0;
      while (rdy === 1'b1 && t < 8) begin
        wr(`MCGTX_ADDR_TXBUF, 8'h3c);
        t = t + 1;
      end
      chk(t, 5);
      rdc(`MCGTX_ADDR_STATUS, 8'h07);
      wr(`MCGTX_ADDR_TXBUF, 8'hc3);
      repeat (400) @(posedge clk);
      #1;
      chk(gap, 64);
      chk(rx_word, 8'h3c);
      chk(n_irq - n0, 5);
      $display("stream done at %0t", $time);
    end
  endtask
  task t_late;
    begin
      wr(`MCGTX_ADDR_BITCNT, 8'h00);
      nbits = 4'h1;
      wr(`MCGTX_ADDR_TXBUF, 8'h01);
      wirq;
      repeat (3) @(posedge clk);
      wr(`MCGTX_ADDR_TXBUF, 8'h00);
      wirq;
      @(posedge clk);
      #1;
      chk(gap, 10);
      repeat (20) @(posedge clk);
      $display("late done at %0t", $time);
    end
  endtask
  task t_off;
    begin
      wr(`MCGTX_ADDR_CTL_A, 8'h00);
      wr(`MCGTX_ADDR_CTL_A, 8'h01);
      n0 = n_irq;
      wr(`MCGTX_ADDR_TXBUF, 8'h55);
      repeat (40) @(posedge clk);
      #1;
      chk(n_irq - n0, 0);
      chk(pin, 1);
      rdc(`MCGTX_ADDR_STATUS, 8'h04);
      rdc(`MCGTX_ADDR_TXBUF, 8'h55);
      // Plain format: the held one-bit unit goes out at enable
      wr(`MCGTX_ADDR_CTL_A, 8'h92);
      wirq;
      repeat (6) @(posedge clk);
      #1;
      chk(pin, 1);
      repeat (4) @(posedge clk);
      #1;
      chk(pin, 0);
      chk(n_irq - n0, 1);
      $display("off done at %0t", $time);
    end
  endtask
  task conclude;
    begin
      $display("%0d checks, %0d errors", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    conclude;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_regs;
    unit(3'h1, 5'h05, 8'h81, 3'h3, 8'h0c, 8'h03);
    unit(3'h5, 5'h03, 8'h91, 3'h0, 8'h01, 8'h01);
    unit(3'h2, 5'h1f, 8'h80, 3'h6, 8'h5a, 8'h2d);
    unit(3'h0, 5'h04, 8'h90, 3'h7, 8'ha5, 8'ha5);
    t_stream;
    t_late;
    t_off;
    conclude;
  end
endmodule
